// ===== rtl/iox_expander.v
`timescale 1ns/1ps
`include "iox_defines.vh"
// Summary of operation
// - Start is SDA falling while SCL high; device then receives address.
// - Address byte arrives MSB first, direction bit last; shifted in so.
// - On own address, device holds SDA low through ack clock high.
// - One bit per SCL pulse; SDA change while SCL high is start/stop.
// - Stop is SDA rising while SCL high; device ends the transaction.
// - Any number of bytes; each is eight bits plus one ack slot.
// - Transmitter releases SDA for ack; acknowledger holds it low.
// - Device acks every received byte; master acks each read byte but the last.
// - Master NACK ends a read; device then releases SDA.
// - Slave address is 010000 plus strap bit: 0x20 or 0x21.
// - Last address bit one means read, zero means write.
// - First write byte after address is the command, stored as pointer.
// - Low two command bits select input, output, invert or direction.
// - Register 0 reads live pin levels; writes ignored; no reset value.
// - Output register drives output pins; reads return stored value; resets FF.
// - Set invert bits flip corresponding pin levels; mask resets to zero.
// - Direction one means input, zero output; resets to all ones.
// - Output pin enables high or low switch by bit; input disables both.
// - Power-on reset loads defaults and initialises the bus machine.
// - Reset pin low returns registers and bus machine to defaults.
// - Written byte loads into register on rising SCL of its ack pulse.
module iox_expander (
  input  wire       i_core_clk,
  input  wire       i_reset_n,
  input  wire       i_por_n,
  input  wire       i_scl,
  input  wire       i_sda,
  output reg        o_sda,
  output reg        o_sda_oe_n,
  input  wire       i_addr_strap,
  input  wire [7:0] i_pin,
  output reg  [7:0] o_high_side_switch,
  output reg  [7:0] o_low_side_switch
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  wire [10:0] sync_w;
  wire        scl_s;
  wire        sda_s;
  wire        strap_s;
  wire [7:0]  pin_s;
  reg         rst_pin_meta_q;
  reg         rst_pin_q;
  reg         por_meta_q;
  reg         por_q;
  wire        rst_n;

  // Reset and power-on reset come from pins; raw and synchronised copies are ANDed, so assertion acts at once and release is synchronised
  always @(posedge i_core_clk) begin
    rst_pin_meta_q <= i_reset_n;
    rst_pin_q      <= rst_pin_meta_q;
    por_meta_q     <= i_por_n;
    por_q          <= por_meta_q;
  end
  assign rst_n = i_reset_n & rst_pin_q & i_por_n & por_q;

  iox_sync2 #(
    .WIDTH     (11),
    .RESET_VAL (11'h7FF)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_reset_n  (rst_n),
    .i_async    ({i_scl, i_sda, i_addr_strap, i_pin}),
    .o_sync     (sync_w)
  );
  assign scl_s   = sync_w[10];
  assign sda_s   = sync_w[9];
  assign strap_s = sync_w[8];
  assign pin_s   = sync_w[7:0];

  // ----------------------------------------
  // Edge and condition detection
  // ----------------------------------------
  reg  scl_prev_q;
  reg  sda_prev_q;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;

  always @(posedge i_core_clk) begin
    if (!rst_n) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end
  assign scl_rise   = scl_s & ~scl_prev_q;
  assign scl_fall   = ~scl_s & scl_prev_q;
  // SDA moving while SCL stays high is a bus condition, never data
  assign start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_cond  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [2:0] state_q;
  reg  [3:0] bit_cnt_q;
  reg  [7:0] shift_q;
  reg        first_byte_q;
  reg        nack_q;
  reg  [7:0] command_q;
  reg  [7:0] pin_drive_value_q;
  reg  [7:0] input_invert_mask_q;
  reg  [7:0] direction_select_q;
  wire [7:0] pin_level_in;
  reg  [7:0] rd_data;
  wire       addr_match;

  // Live pins, inverted where the mask says; no stored copy so no reset value
  assign pin_level_in = pin_s ^ input_invert_mask_q;

  always @* begin
    case (command_q[1:0])
      `IOX_REG_PIN_LEVEL_IN:      rd_data = pin_level_in;
      `IOX_REG_PIN_DRIVE_VALUE:   rd_data = pin_drive_value_q;
      `IOX_REG_INPUT_INVERT_MASK: rd_data = input_invert_mask_q;
      default:                    rd_data = direction_select_q;
    endcase
  end

  // Strap assumed steady over the transaction; sampled live
  assign addr_match = (shift_q[7:1] == {`IOX_ADDR_FIXED, strap_s});

  // ----------------------------------------
  // Bus state machine
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    if (!rst_n) begin
      state_q             <= `IOX_ST_IDLE;
      bit_cnt_q           <= 4'h0;
      shift_q             <= 8'h00;
      first_byte_q        <= 1'b0;
      nack_q              <= 1'b0;
      command_q           <= `IOX_RST_COMMAND;
      pin_drive_value_q   <= `IOX_RST_PIN_DRIVE_VALUE;
      input_invert_mask_q <= `IOX_RST_INPUT_INVERT_MASK;
      direction_select_q  <= `IOX_RST_DIRECTION_SELECT;
      o_sda               <= 1'b1;
      o_sda_oe_n          <= 1'b1;
    end else if (start_cond) begin
      // Repeated start also lands here
      state_q    <= `IOX_ST_ADDR;
      bit_cnt_q  <= 4'h0;
      o_sda      <= 1'b1;
      o_sda_oe_n <= 1'b1;
    end else if (stop_cond) begin
      state_q    <= `IOX_ST_IDLE;
      o_sda      <= 1'b1;
      o_sda_oe_n <= 1'b1;
    end else begin
      case (state_q)
        `IOX_ST_IDLE: begin
          o_sda_oe_n <= 1'b1;
        end
        `IOX_ST_ADDR, `IOX_ST_WR_BYTE: begin
          if (scl_rise) begin
            shift_q   <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          // Ack driven on the fall after the eighth bit; counting to eight
          // keeps the clock fall that closes a start from ending a byte
          if (scl_fall && bit_cnt_q == 4'h8) begin
            if (state_q == `IOX_ST_WR_BYTE) begin
              state_q    <= `IOX_ST_WR_ACK;
              o_sda      <= 1'b0;
              o_sda_oe_n <= 1'b0;
            end else if (addr_match) begin
              state_q    <= `IOX_ST_ADDR_ACK;
              o_sda      <= 1'b0;
              o_sda_oe_n <= 1'b0;
            end else begin
              state_q <= `IOX_ST_IDLE;
            end
          end
        end
        `IOX_ST_ADDR_ACK: begin
          // Ack held low over the whole high phase; on the fall, released for a write or first read bit driven
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (shift_q[0]) begin
              state_q    <= `IOX_ST_RD_BYTE;
              shift_q    <= {rd_data[6:0], 1'b0};
              o_sda      <= rd_data[7];
              o_sda_oe_n <= rd_data[7];
            end else begin
              state_q      <= `IOX_ST_WR_BYTE;
              first_byte_q <= 1'b1;
              o_sda        <= 1'b1;
              o_sda_oe_n   <= 1'b1;
            end
          end
        end
        `IOX_ST_WR_ACK: begin
          if (scl_rise) begin
            first_byte_q <= 1'b0;
            if (first_byte_q) begin
              command_q <= shift_q;
            end else begin
              case (command_q[1:0])
                `IOX_REG_PIN_DRIVE_VALUE:   pin_drive_value_q   <= shift_q;
                `IOX_REG_INPUT_INVERT_MASK: input_invert_mask_q <= shift_q;
                `IOX_REG_DIRECTION_SELECT:  direction_select_q  <= shift_q;
                default:                    ;
              endcase
            end
          end
          if (scl_fall) begin
            state_q    <= `IOX_ST_WR_BYTE;
            bit_cnt_q  <= 4'h0;
            o_sda      <= 1'b1;
            o_sda_oe_n <= 1'b1;
          end
        end
        `IOX_ST_RD_BYTE: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          if (scl_fall) begin
            if (bit_cnt_q == 4'h8) begin
              state_q    <= `IOX_ST_RD_ACK;
              o_sda      <= 1'b1;
              o_sda_oe_n <= 1'b1;
            end else begin
              shift_q    <= {shift_q[6:0], 1'b0};
              o_sda      <= shift_q[7];
              o_sda_oe_n <= shift_q[7];
            end
          end
        end
        `IOX_ST_RD_ACK: begin
          if (scl_rise) begin
            nack_q <= sda_s;
          end
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (nack_q) begin
              state_q <= `IOX_ST_IDLE;
            end else begin
              // Register reread per byte, so pin levels stay fresh
              state_q    <= `IOX_ST_RD_BYTE;
              shift_q    <= {rd_data[6:0], 1'b0};
              o_sda      <= rd_data[7];
              o_sda_oe_n <= rd_data[7];
            end
          end
        end
        default: begin
          state_q <= `IOX_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // Registered so both switches never overlap mid-update
  always @(posedge i_core_clk) begin
    if (!rst_n) begin
      o_high_side_switch <= 8'h00;
      o_low_side_switch  <= 8'h00;
    end else begin
      o_high_side_switch <= ~direction_select_q & pin_drive_value_q;
      o_low_side_switch  <= ~direction_select_q & ~pin_drive_value_q;
    end
  end
endmodule // iox_expander

// ===== rtl/iox_sync2.v
`timescale 1ns/1ps
// ----------------------------------------
// Two-flop synchroniser
// ----------------------------------------
module iox_sync2 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
  input  wire             i_core_clk,
  input  wire             i_reset_n,
  input  wire [WIDTH-1:0] i_async,
  output reg  [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_q;

  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      meta_q <= RESET_VAL;
      o_sync <= RESET_VAL;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule // iox_sync2

// ===== shared/iox_defines.vh
`ifndef IOX_DEFINES_VH
`define IOX_DEFINES_VH
// ----------------------------------------
// Register map and resets
// ----------------------------------------
`define IOX_REG_PIN_LEVEL_IN      2'h0
`define IOX_REG_PIN_DRIVE_VALUE   2'h1
`define IOX_REG_INPUT_INVERT_MASK 2'h2
`define IOX_REG_DIRECTION_SELECT  2'h3
`define IOX_RST_PIN_DRIVE_VALUE   8'hFF
`define IOX_RST_INPUT_INVERT_MASK 8'h00
`define IOX_RST_DIRECTION_SELECT  8'hFF
`define IOX_RST_COMMAND           8'h00
// ----------------------------------------
// Slave address
// ----------------------------------------
`define IOX_ADDR_FIXED            6'h10
// ----------------------------------------
// Bus state codes
// ----------------------------------------
`define IOX_ST_IDLE               3'h0
`define IOX_ST_ADDR               3'h1
`define IOX_ST_ADDR_ACK           3'h2
`define IOX_ST_WR_BYTE            3'h3
`define IOX_ST_WR_ACK             3'h4
`define IOX_ST_RD_BYTE            3'h5
`define IOX_ST_RD_ACK             3'h6
`endif

// ===== tb/iox_expander_properties.sv
`timescale 1ns/1ps
`include "iox_defines.vh"
// ----------------------------------------
// Bus slot checks
// ----------------------------------------
module iox_expander_properties (
  input logic       i_core_clk,
  input logic       i_reset_n,
  input logic       i_por_n,
  input logic       i_scl,
  input logic       i_sda,
  input logic       o_sda,
  input logic       o_sda_oe_n,
  input logic       i_addr_strap,
  input logic [7:0] i_pin,
  input logic [7:0] o_high_side_switch,
  input logic [7:0] o_low_side_switch
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n || !i_por_n);
  logic       scl_q, sda_q, first_q, rd_q, act_q;
  logic [3:0] nbit_q;
  logic [7:0] sh_q;
  wire rise  = i_scl & ~scl_q;
  wire start = scl_q & i_scl & sda_q & ~i_sda;
  wire stop  = scl_q & i_scl & ~sda_q & i_sda;
  wire slot9 = rise & act_q & (nbit_q == 4'h8);
  wire match = (sh_q[7:1] == {`IOX_ADDR_FIXED, i_addr_strap});
  always_ff @(posedge i_core_clk) begin
    scl_q <= i_scl;
    sda_q <= i_sda;
    if (!i_reset_n || !i_por_n) begin
      act_q <= 1'b0;
      first_q <= 1'b0;
      rd_q <= 1'b0;
      nbit_q <= 4'h0;
      sh_q <= 8'h00;
    end else if (start) begin
      act_q <= 1'b1;
      first_q <= 1'b1;
      nbit_q <= 4'h0;
    end else if (stop) begin
      act_q <= 1'b0;
    end else if (slot9) begin
      nbit_q <= 4'h0;
      first_q <= 1'b0;
      if (first_q) begin
        rd_q <= sh_q[0];
        act_q <= match;
      end
    end else if (rise && act_q) begin
      nbit_q <= nbit_q + 4'h1;
      sh_q <= {sh_q[6:0], i_sda};
    end
  end
  // Sampled a clock late: the drive lands 3 to 4 clocks after the fall
  sequence s_ack_held;
    ##1 !o_sda_oe_n [*3];
  endsequence
  sequence s_released;
    ##1 o_sda_oe_n [*3];
  endsequence
  chk_addr_ack: assert property (slot9 && first_q && match |-> s_ack_held)
    else $error("own address not acknowledged");
  chk_addr_nack: assert property (slot9 && first_q && !match |-> s_released)
    else $error("foreign address acknowledged");
  chk_write_ack: assert property (slot9 && !first_q && !rd_q |-> s_ack_held)
    else $error("written byte not acknowledged");
  chk_read_release: assert property (slot9 && !first_q && rd_q |-> ##2 o_sda_oe_n)
    else $error("line held in master ack slot");
  chk_addr_listen: assert property (
    rise && act_q && first_q && nbit_q < 4'h8 |-> ##1 o_sda_oe_n)
    else $error("line driven during address bits");
  chk_stop_idle: assert property (stop |-> ##[0:8] o_sda_oe_n)
    else $error("line held after stop");
  chk_switch_excl: assert property ((o_high_side_switch & o_low_side_switch) == 8'h00)
    else $error("both switches on one pin");
  chk_oe_mirror: assert property (o_sda_oe_n == o_sda)
    else $error("drive value and enable disagree");
endmodule // iox_expander_properties

// ===== tb/iox_i2c_master.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bus master model
// ----------------------------------------
module iox_i2c_master (
  input  wire  i_core_clk,
  input  wire  i_sda,
  output logic o_scl,
  output logic o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  // Data moves only while the clock is low; 4 + 4 clocks a bit
  task automatic bitx(input logic b, output logic r);
    hold(1);
    o_sda <= b;
    hold(3);
    o_scl <= 1'b1;
    hold(2);
    r = i_sda;
    hold(2);
    o_scl <= 1'b0;
  endtask
  // Longer low phase lets a slave ack end before the clock rises
  task automatic start;
    hold(1);
    o_sda <= 1'b1;
    hold(5);
    o_scl <= 1'b1;
    hold(4);
    o_sda <= 1'b0;
    hold(4);
    o_scl <= 1'b0;
  endtask
  task automatic stop;
    hold(1);
    o_sda <= 1'b0;
    hold(3);
    o_scl <= 1'b1;
    hold(4);
    o_sda <= 1'b1;
    hold(4);
  endtask
  // Sending 1 in the ninth slot releases the line
  task automatic xfer(input logic [7:0] tx, input logic a_tx, output logic [7:0] rx,
                      output logic a_rx);
    for (int i = 7; i >= 0; i--) begin
      bitx(tx[i], rx[i]);
    end
    bitx(a_tx, a_rx);
  endtask
endmodule // iox_i2c_master

// ===== tb/tb_iox_expander.sv
`timescale 1ns/1ps
`include "iox_defines.vh"
// ----------------------------------------
// Expander bench
// ----------------------------------------
module tb_iox_expander;
  logic       clk = 1'b0, rst_n = 1'b0, por_n = 1'b1, strap = 1'b0;
  logic [7:0] pin = 8'h96;
  logic       m_scl, m_sda, dut_sda, dut_oe_n, ack;
  logic [7:0] hs, ls, rx;
  int         err_total = 0, total_checks = 0;
  wire        sda = m_sda & (dut_oe_n | dut_sda);
  initial forever #20 clk = ~clk;
  iox_i2c_master u_mst (.i_core_clk(clk), .i_sda(sda), .o_scl(m_scl), .o_sda(m_sda));
  iox_expander u_dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_por_n(por_n), .i_scl(m_scl),
    .i_sda(sda), .o_sda(dut_sda), .o_sda_oe_n(dut_oe_n), .i_addr_strap(strap), .i_pin(pin),
    .o_high_side_switch(hs), .o_low_side_switch(ls));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic pulse(input logic por);
    @(posedge clk);
    if (por) por_n <= 1'b0;
    else rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    por_n <= 1'b1;
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
                    input int n, input logic ea);
    u_mst.start();
    u_mst.xfer({a, 1'b0}, 1'b1, rx, ack);
    chk("addr ack", ack, ea);
    if (ea == 1'b0) begin
      u_mst.xfer(c, 1'b1, rx, ack);
      chk("cmd ack", ack, 8'h00);
      for (int i = 0; i < n; i++) begin
        u_mst.xfer(d[15-8*i -: 8], 1'b1, rx, ack);
        chk("data ack", ack, 8'h00);
      end
    end
    u_mst.stop();
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] exp, input int n, input logic wp);
    if (wp) begin
      u_mst.start();
      u_mst.xfer({`IOX_ADDR_FIXED, strap, 1'b0}, 1'b1, rx, ack);
      u_mst.xfer(c, 1'b1, rx, ack);
    end
    u_mst.start();
    u_mst.xfer({`IOX_ADDR_FIXED, strap, 1'b1}, 1'b1, rx, ack);
    chk("read addr ack", ack, 8'h00);
    for (int i = 0; i < n; i++) begin
      u_mst.xfer(8'hFF, (i == n - 1), rx, ack);
      chk("read data", rx, exp);
    end
    u_mst.stop();
  endtask
  initial begin
    pulse(1'b0);
    rd(`IOX_REG_PIN_DRIVE_VALUE, `IOX_RST_PIN_DRIVE_VALUE, 1, 1);
    rd(`IOX_REG_INPUT_INVERT_MASK, `IOX_RST_INPUT_INVERT_MASK, 1, 1);
    rd(`IOX_REG_DIRECTION_SELECT, `IOX_RST_DIRECTION_SELECT, 2, 1);
    chk("high idle", hs | ls, 8'h00);
    wr({`IOX_ADDR_FIXED, 1'b0}, 8'h03, 16'h0F00, 1, 1'b0);
    wr({`IOX_ADDR_FIXED, 1'b0}, 8'h01, 16'h3CA5, 2, 1'b0);
    chk("high switches", hs, 8'hA0);
    chk("low switches", ls, 8'h50);
    rd(8'h01, 8'hA5, 1, 1);
    wr({`IOX_ADDR_FIXED, 1'b0}, 8'h00, 16'h5500, 1, 1'b0);
    wr({`IOX_ADDR_FIXED, 1'b0}, 8'hFE, 16'h0F00, 1, 1'b0);
    rd(8'h00, 8'h99, 1, 1);
    pin <= 8'h3C;
    rd(8'h00, 8'h33, 1, 0);
    strap <= 1'b1;
    wr({`IOX_ADDR_FIXED, 1'b0}, 8'h01, 16'h0000, 1, 1'b1);
    rd(8'h01, 8'hA5, 1, 1);
    rd(8'hFE, 8'h0F, 1, 1);
    pulse(1'b0);
    chk("reset switches", hs | ls, 8'h00);
    wr({`IOX_ADDR_FIXED, 1'b1}, 8'h03, 16'h0000, 1, 1'b0);
    chk("all high", hs, 8'hFF);
    pulse(1'b1);
    chk("por switches", hs | ls, 8'h00);
    rd(8'h03, 8'hFF, 1, 1);
    report_and_stop();
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
endmodule // tb_iox_expander
bind iox_expander iox_expander_properties u_chk (
  .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_por_n(i_por_n), .i_scl(i_scl),
  .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .i_addr_strap(i_addr_strap),
  .i_pin(i_pin), .o_high_side_switch(o_high_side_switch), .o_low_side_switch(o_low_side_switch));
